//--- sol_pkg.sv
// Constants and types of the sensor output low-pass filter
`default_nettype none

package sol_pkg;

  // ==========================================================
  // Widths
  localparam int X_W = 24;
  localparam int CH_W = 2;
  localparam int N_CH = 4;
  localparam int FRAC_W = 16;
  localparam int ACC_W = X_W + FRAC_W;
  localparam int SEL_W = 5;
  localparam int ALPHA_W = 16;
  localparam int ADDR_W = 8;
  localparam int FIFO_DEPTH = 4;
  localparam int LVL_W = 3;

  // ==========================================================
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_TAU_STAGE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STORE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_TAU_ACTIVE = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;

  // ==========================================================
  // Field positions and reset values
  localparam int MODE_LSB = 0;
  localparam int TAU_STRIDE = 8;
  localparam int STORE_GO_BIT = 0;
  localparam int ST_ACTIVE_BIT = 0;
  localparam int ST_LEVEL_LSB = 4;
  localparam int ST_PRIMED_LSB = 16;
  localparam logic [SEL_W-1:0] SEL_BYPASS = 5'h00;
  localparam logic [SEL_W-1:0] SEL_MAX = 5'h15;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
  // Settling reaches 99.3 percent after this many time constants
  localparam int SETTLE_TAUS = 5;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {MODE_COMMAND, MODE_CYCLIC, MODE_STEP, MODE_RSVD} sol_mode_type;
  typedef enum logic {FSM_IDLE, FSM_CALC} sol_fsm_type;

  typedef struct packed {
    logic [CH_W-1:0] chan;
    logic signed [X_W-1:0] data;
  } sol_samp_type;

  // ==========================================================
  // Gain per time constant, alpha = 1 - exp(-1/tau), unsigned Q16
  function automatic logic [ALPHA_W-1:0] sol_alpha(input logic [SEL_W-1:0] sel);
    case (sel)
      5'h01: sol_alpha = 16'hE000; // tau 0.481
      5'h02: sol_alpha = 16'hC000; // tau 0.721
      5'h03: sol_alpha = 16'hA000; // tau 1.02
      5'h04: sol_alpha = 16'h8000; // tau 1.443
      5'h05: sol_alpha = 16'h7000; // tau 1.738
      5'h06: sol_alpha = 16'h6000; // tau 2.128
      5'h07: sol_alpha = 16'h5000; // tau 2.669
      5'h08: sol_alpha = 16'h4000; // tau 3.476
      5'h09: sol_alpha = 16'h3800; // tau 4.051
      5'h0A: sol_alpha = 16'h3000; // tau 4.816
      5'h0B: sol_alpha = 16'h2800; // tau 5.886
      5'h0C: sol_alpha = 16'h2000; // tau 7.489
      5'h0D: sol_alpha = 16'h1C00; // tau 8.633
      5'h0E: sol_alpha = 16'h1800; // tau 10.158
      5'h0F: sol_alpha = 16'h1400; // tau 12.293
      5'h10: sol_alpha = 16'h1000; // tau 15.495
      5'h11: sol_alpha = 16'h0E00; // tau 17.781
      5'h12: sol_alpha = 16'h0C00; // tau 20.829
      5'h13: sol_alpha = 16'h0A00; // tau 25.097
      5'h14: sol_alpha = 16'h0800; // tau 31.497
      5'h15: sol_alpha = 16'h0600; // tau 42.165
      default: sol_alpha = 16'h0000;
    endcase
  endfunction : sol_alpha

endpackage : sol_pkg

`default_nettype wire

//--- sol_fifo.sv
// Shift-register FIFO whose head entry is always a flip-flop
`default_nettype none

module sol_fifo #(
  parameter int W = 26,
  parameter int DEPTH = 4,
  parameter int LW = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic s_valid,
  output logic s_ready,
  input wire logic [W-1:0] s_data,
  // Drain side
  output logic m_valid,
  input wire logic m_ready,
  output logic [W-1:0] m_data,
  // Fill level
  output logic [LW-1:0] level
);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [DEPTH-1:0] vld;
  } fifo_st_type;

  fifo_st_type st;
  fifo_st_type next_st;

  assign s_ready = !st.vld[DEPTH-1];
  assign m_valid = st.vld[0];
  assign m_data = st.mem[0];

  // ==========================================================
  // Pop shifts down, push fills the lowest free slot
  always_comb
  begin
    logic done;
    done = 1'b0;
    next_st = st;
    level = '0;
    for (int i = 0; i < DEPTH; i++)
    begin
      level = level + LW'(st.vld[i]);
    end
    if (st.vld[0] && m_ready)
    begin
      for (int i = 0; i < DEPTH - 1; i++)
      begin
        next_st.mem[i] = st.mem[i+1];
        next_st.vld[i] = st.vld[i+1];
      end
      next_st.vld[DEPTH-1] = 1'b0;
    end
    if (s_valid && s_ready)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        if (!done && !next_st.vld[i])
        begin
          next_st.mem[i] = s_data;
          next_st.vld[i] = 1'b1;
          done = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

endmodule : sol_fifo

`default_nettype wire

//--- sol_state_mem.sv
// Per-channel filter accumulator store with registered read
`default_nettype none

module sol_state_mem #(
  parameter int W = 40,
  parameter int N = 4,
  parameter int AW = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Read port
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data
);

  typedef struct packed {
    logic [N-1:0][W-1:0] mem;
    logic [W-1:0] rd;
  } mem_st_type;

  mem_st_type st;
  mem_st_type next_st;

  assign rd_data = st.rd;

  // ==========================================================
  // Read returns contents before a same-cycle write
  always_comb
  begin
    next_st = st;
    next_st.rd = st.mem[rd_addr];
    if (we)
      next_st.mem[wr_addr] = wr_data;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

endmodule : sol_state_mem

`default_nettype wire

//--- sol_iir.sv
// Per-channel first-order IIR low-pass filter with APB registers
`default_nettype none

module sol_iir (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // APB slave
  input wire logic [sol_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Conditioned samples in
  input wire logic in_valid,
  output logic in_ready,
  input wire sol_pkg::sol_samp_type in_sample,
  // Filtered samples out
  output logic out_valid,
  input wire logic out_ready,
  output sol_pkg::sol_samp_type out_sample
);

  import sol_pkg::*;

  typedef struct packed {
    sol_fsm_type fsm;
    sol_mode_type mode;
    logic [N_CH-1:0][SEL_W-1:0] tau_stage;
    logic [N_CH-1:0][SEL_W-1:0] nonvolatile_config_store;
    logic [N_CH-1:0] primed;
    sol_samp_type cur;
    logic in_ready;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } sol_st_type;

  sol_st_type st;
  sol_st_type next_st;
  logic [1:0] rst_sync;
  logic rst_n;
  logic [CH_W-1:0] mem_rd_addr;
  logic [ACC_W-1:0] mem_rd_data;
  logic mem_we;
  logic [ACC_W-1:0] mem_wr_data;
  logic fifo_push;
  logic fifo_s_ready;
  sol_samp_type fifo_in;
  logic [LVL_W-1:0] fifo_level;

  // ==========================================================
  // Helpers
  function automatic logic sol_addr_ok(input logic [ADDR_W-1:0] a);
    sol_addr_ok = (a == OFS_CTRL)
      || (a == OFS_TAU_STAGE)
      || (a == OFS_STORE)
      || (a == OFS_TAU_ACTIVE)
      || (a == OFS_STATUS);
  endfunction : sol_addr_ok

  function automatic logic [31:0] sol_pack_tau(input logic [N_CH-1:0][SEL_W-1:0] t);
    sol_pack_tau = RDATA_ZERO;
    for (int i = 0; i < N_CH; i++)
    begin
      sol_pack_tau[i*TAU_STRIDE +: SEL_W] = t[i];
    end
  endfunction : sol_pack_tau

  function automatic logic signed [X_W-1:0] sol_round(input logic signed [ACC_W-1:0] a);
    logic signed [ACC_W:0] s;
    s = {a[ACC_W-1], a} + (ACC_W+1)'(1 << (FRAC_W - 1));
    sol_round = s[ACC_W-1:FRAC_W];
  endfunction : sol_round

  function automatic logic signed [ACC_W:0] sol_sext(input logic [ACC_W-1:0] a);
    sol_sext = $signed({a[ACC_W-1], a});
  endfunction : sol_sext

  function automatic logic sol_cyclic(input sol_mode_type m);
    sol_cyclic = (m == MODE_CYCLIC);
  endfunction : sol_cyclic

  // ==========================================================
  // Reset release synchroniser
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_sync <= 2'b00;
    end
    else
    begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_n = rst_sync[1];

  // ==========================================================
  // Outputs
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign in_ready = st.in_ready;

  // ==========================================================
  // Next state
  always_comb
  begin
    logic [SEL_W-1:0] sel;
    logic [ACC_W-1:0] x_acc;
    logic signed [ACC_W:0] diff;
    logic signed [ACC_W+FRAC_W+1:0] prod;
    logic signed [ACC_W:0] sum;
    logic [31:0] rd;
    logic locked;
    logic bypass;
    logic [CH_W-1:0] ch;
    sel = SEL_BYPASS;
    x_acc = '0;
    diff = '0;
    prod = '0;
    sum = '0;
    rd = RDATA_ZERO;
    next_st = st;
    mem_rd_addr = in_sample.chan;
    mem_we = 1'b0;
    mem_wr_data = '0;
    fifo_push = 1'b0;
    fifo_in = st.cur;
    locked = (st.mode == MODE_STEP);
    bypass = 1'b1;
    ch = st.cur.chan;

    // APB: answer one cycle into the access phase
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    case (paddr)
      OFS_CTRL: rd[MODE_LSB +: 2] = st.mode;
      OFS_TAU_STAGE: rd = sol_pack_tau(st.tau_stage);
      OFS_TAU_ACTIVE: rd = sol_pack_tau(st.nonvolatile_config_store);
      OFS_STATUS:
      begin
        rd[ST_ACTIVE_BIT] = sol_cyclic(st.mode);
        rd[ST_LEVEL_LSB +: LVL_W] = fifo_level;
        rd[ST_PRIMED_LSB +: N_CH] = st.primed;
      end
      default: rd = RDATA_ZERO;
    endcase
    if (psel && penable && !st.pready)
    begin
      next_st.pready = 1'b1;
      next_st.pslverr = !sol_addr_ok(paddr);
      next_st.prdata = pwrite ? RDATA_ZERO : rd;
    end
    if (psel && penable && st.pready && pwrite)
    begin
      case (paddr)
        OFS_CTRL:
        begin
          if (pwdata[MODE_LSB +: 2] != MODE_RSVD)
          begin
            next_st.mode = sol_mode_type'(pwdata[MODE_LSB +: 2]);
          end
        end
        OFS_TAU_STAGE:
        begin
          if (!locked)
          begin
            for (int i = 0; i < N_CH; i++)
            begin
              next_st.tau_stage[i] = pwdata[i*TAU_STRIDE +: SEL_W];
            end
          end
        end
        OFS_STORE:
        begin
          if (!locked && pwdata[STORE_GO_BIT])
          begin
            next_st.nonvolatile_config_store = st.tau_stage;
          end
        end
        default: next_st.mode = st.mode;
      endcase
    end

    // Sample path, one sample per two cycles, every channel alike
    case (st.fsm)
      FSM_IDLE:
      begin
        if (in_valid && st.in_ready)
        begin
          next_st.cur = in_sample;
          next_st.fsm = FSM_CALC;
        end
      end
      FSM_CALC:
      begin
        sel = st.nonvolatile_config_store[ch];
        x_acc = {st.cur.data, FRAC_W'(0)};
        bypass = !sol_cyclic(st.mode) || (sel == SEL_BYPASS) || (sel > SEL_MAX);
        mem_we = 1'b1;
        fifo_push = 1'b1;
        next_st.fsm = FSM_IDLE;
        if (bypass)
        begin
          mem_wr_data = x_acc;
        end
        else if (!st.primed[ch])
        begin
          mem_wr_data = x_acc;
          next_st.primed[ch] = 1'b1;
        end
        else
        begin
          // y += alpha * (x - y), exponential step response
          diff = sol_sext(x_acc) - sol_sext(mem_rd_data);
          prod = diff * $signed({1'b0, sol_alpha(sel)});
          sum = sol_sext(mem_rd_data) + prod[ACC_W+FRAC_W:FRAC_W];
          mem_wr_data = sum[ACC_W-1:0];
          fifo_in.data = sol_round(sum[ACC_W-1:0]);
        end
      end
      default: next_st.fsm = FSM_IDLE;
    endcase

    // Leaving cyclic mode forgets history so re-entry preloads
    if (!sol_cyclic(st.mode))
    begin
      next_st.primed = '0;
    end

    // Accept only with room for the result already under way
    next_st.in_ready = (next_st.fsm == FSM_IDLE)
      && (fifo_level < LVL_W'(FIFO_DEPTH - 1))
      && fifo_s_ready;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.fsm <= FSM_IDLE;
      st.mode <= MODE_COMMAND;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Channel state and output buffer
  sol_state_mem #(
    .W(ACC_W),
    .N(N_CH),
    .AW(CH_W)
  ) u_state (
    .clk(clk),
    .rst_n(rst_n),
    .rd_addr(mem_rd_addr),
    .rd_data(mem_rd_data),
    .we(mem_we),
    .wr_addr(st.cur.chan),
    .wr_data(mem_wr_data)
  );

  sol_fifo #(
    .W($bits(sol_samp_type)),
    .DEPTH(FIFO_DEPTH),
    .LW(LVL_W)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .s_valid(fifo_push),
    .s_ready(fifo_s_ready),
    .s_data(fifo_in),
    .m_valid(out_valid),
    .m_ready(out_ready),
    .m_data(out_sample),
    .level(fifo_level)
  );

endmodule : sol_iir

`default_nettype wire

//--- sol_iir_asserts.sv
// Port protocol checker of the sensor output filter
`default_nettype none

module sol_iir_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // APB slave
  input wire logic [sol_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Sample streams
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire sol_pkg::sol_samp_type out_sample
);
  timeunit 1ns;
  timeprecision 1ps;
  import sol_pkg::*;
  logic acc_ph;
  logic bad_adr;
  assign acc_ph = psel && penable && !pready;
  assign bad_adr = (paddr > OFS_STATUS) || (paddr[1:0] != 2'b00);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // ==========================================================
  // Register bus answer
  a_one_wait: assert property (acc_ph |=> pready)
    else $error("pready late");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_unmapped_err: assert property (acc_ph && bad_adr |=> pready && pslverr)
    else $error("no error on unmapped");
  a_mapped_ok: assert property (acc_ph && !bad_adr |=> !pslverr)
    else $error("error on mapped");
  a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == RDATA_ZERO)
    else $error("error read not zero");
  // ==========================================================
  // Sample streams
  a_accept_gap: assert property (in_valid && in_ready |=> !in_ready)
    else $error("second sample too soon");
  a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_sample))
    else $error("output head changed");
endmodule : sol_iir_chk

bind sol_iir sol_iir_chk sol_iir_chk_i (.clk(clk), .arst_n(arst_n), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .in_valid(in_valid), .in_ready(in_ready), .out_valid(out_valid), .out_ready(out_ready),
  .out_sample(out_sample));

`default_nettype wire

//--- sol_sink.sv
// Downstream output stage model that drains filtered samples
`default_nettype none

module sol_sink (
  // Clock
  input wire logic clk,
  // Hold-off request
  input wire logic stall,
  // Filtered samples
  input wire logic out_valid,
  output logic out_ready,
  input wire sol_pkg::sol_samp_type out_sample
);
  timeunit 1ns;
  timeprecision 1ps;
  import sol_pkg::*;
  sol_samp_type got_q[$];
  // ==========================================================
  // Drain in order, holding off while stalled
  assign out_ready = !stall;
  always @(posedge clk)
  begin
    if (out_valid && out_ready)
    begin
      got_q.push_back(out_sample);
    end
  end
endmodule : sol_sink

`default_nettype wire

//--- test_sol_iir.sv
// Self-checking bench of the sensor output filter
`default_nettype none
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin n_mismatch++; \
  $display("BAD %s expected %h seen %h", nm, ex, gt); end end

module test_sol_iir;
  timeunit 1ns;
  timeprecision 1ps;
  import sol_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic in_valid = 1'b0;
  logic in_ready;
  sol_samp_type in_sample = 26'h000_0000;
  logic out_valid;
  logic out_ready;
  sol_samp_type out_sample;
  logic stall = 1'b0;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [31:0] rd;
  logic err;
  logic [31:0] wd;
  sol_samp_type got;
  longint acc;
  logic [X_W-1:0] y;
  logic [ADDR_W-1:0] ofs[5] = '{OFS_CTRL, OFS_TAU_STAGE, OFS_STORE, OFS_TAU_ACTIVE, OFS_STATUS};

  always #2.5 clk = ~clk;

  sol_iir sol_iir_i (.clk(clk), .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .in_valid(in_valid), .in_ready(in_ready), .in_sample(in_sample), .out_valid(out_valid),
    .out_ready(out_ready), .out_sample(out_sample));
  sol_sink sol_sink_i (.clk(clk), .stall(stall), .out_valid(out_valid), .out_ready(out_ready),
    .out_sample(out_sample));

  // ==========================================================
  // Closing report
  task automatic results();
    $display("Mismatches %0d of %0d checks", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
    begin
      $display("ALL TESTS PASSED");
    end
    else
    begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  task automatic hang();
    n_mismatch++;
    $display("BAD wait expected answer seen none");
    results();
  endtask : hang

  // ==========================================================
  // Bus, stream and compare tasks
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) hang();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0000_0000);
    `CHK("register", ex, rd)
  endtask : rchk

  task automatic push(input logic [CH_W-1:0] c, input logic [X_W-1:0] d);
    int i;
    in_valid <= 1'b1;
    in_sample <= {c, d};
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (in_ready !== 1'b1 && i < 50);
    if (in_ready !== 1'b1) hang();
    in_valid <= 1'b0;
    @(posedge clk);
  endtask : push

  task automatic expect_out(input logic [CH_W-1:0] c, input logic [X_W-1:0] d);
    int i;
    for (i = 0; i < 50 && sol_sink_i.got_q.size() == 0; i++) @(negedge clk);
    if (i == 50) hang();
    got = sol_sink_i.got_q.pop_front();
    `CHK("out chan", c, got.chan)
    `CHK("out data", d, got.data)
    @(posedge clk);
  endtask : expect_out

  // ==========================================================
  // Scenarios
  initial
  begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (ofs[j]) rchk(ofs[j], RDATA_ZERO);
    apb(1'b0, 8'h14, 32'h0000_0000);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", RDATA_ZERO, rd)
    push(2'h0, 24'h12_3456);
    expect_out(2'h0, 24'h12_3456);
    apb(1'b1, OFS_TAU_STAGE, 32'h0000_1604);
    rchk(OFS_TAU_ACTIVE, RDATA_ZERO);
    apb(1'b1, OFS_STORE, 32'h0000_0001);
    rchk(OFS_TAU_ACTIVE, 32'h0000_1604);
    rchk(OFS_STORE, RDATA_ZERO);
    push(2'h0, 24'h00_0100);
    expect_out(2'h0, 24'h00_0100);
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    push(2'h0, 24'h00_0000);
    expect_out(2'h0, 24'h00_0000);
    acc = 0;
    for (int k = 1; k <= 10; k++)
    begin
      push(2'h0, 24'h00_0100);
      acc = acc + ((longint'(32'h0000_8000) * (longint'(32'h0100_0000) - acc)) >>> 16);
      y = X_W'((acc + longint'(32'h0000_8000)) >>> 16);
      expect_out(2'h0, y);
      if (k == 8) `CHK("settled", 1'b1, got.data >= 24'h00_00FF)
      push(2'h1, 24'hF0_0000);
      expect_out(2'h1, 24'hF0_0000);
    end
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    `CHK("filtering", 1'b1, rd[ST_ACTIVE_BIT])
    `CHK("primed", 1'b1, rd[ST_PRIMED_LSB])
    apb(1'b1, OFS_CTRL, 32'h0000_0002);
    apb(1'b1, OFS_TAU_STAGE, 32'h0000_0000);
    rchk(OFS_TAU_STAGE, 32'h0000_1604);
    push(2'h0, 24'h00_0064);
    expect_out(2'h0, 24'h00_0064);
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    push(2'h0, 24'h00_0040);
    expect_out(2'h0, 24'h00_0040);
    push(2'h0, 24'h00_0080);
    expect_out(2'h0, 24'h00_0060);
    apb(1'b1, OFS_CTRL, 32'h0000_0000);
    apb(1'b1, OFS_CTRL, 32'h0000_0003);
    rchk(OFS_CTRL, RDATA_ZERO);
    apb(1'b1, 8'h14, 32'h0000_0001);
    `CHK("unmapped wr err", 1'b1, err)
    for (int s = 0; s <= 21; s++)
    begin
      wd = {3'h0, SEL_W'(s), 24'h00_1604};
      apb(1'b1, OFS_TAU_STAGE, wd);
      apb(1'b1, OFS_STORE, 32'h0000_0001);
      rchk(OFS_TAU_ACTIVE, wd);
    end
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    push(2'h3, 24'h00_0000);
    expect_out(2'h3, 24'h00_0000);
    push(2'h3, 24'h00_1000);
    expect_out(2'h3, 24'h00_0060);
    push(2'h2, 24'h00_0055);
    expect_out(2'h2, 24'h00_0055);
    stall <= 1'b1;
    for (int k = 1; k <= 3; k++) push(2'h2, X_W'(k));
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    `CHK("fifo level", 3'h3, rd[ST_LEVEL_LSB +: LVL_W])
    `CHK("in_ready full", 1'b0, in_ready)
    stall <= 1'b0;
    for (int k = 1; k <= 3; k++) expect_out(2'h2, X_W'(k));
    results();
  end
endmodule : test_sol_iir

`undef CHK
`default_nettype wire
